// [mph_consts.vh]
`ifndef MPH_CONSTS_VH
`define MPH_CONSTS_VH

// ---------------------------------------------------------------
// clock
// ---------------------------------------------------------------
`define MPH_CLK_PERIOD_NS    10

// ---------------------------------------------------------------
// port address classes
// ---------------------------------------------------------------
`define MPH_ADDR_W           3
`define MPH_DATA_W           8
`define MPH_ADDR_SHARED      3'h0
`define MPH_ADDR_MED_SEP     3'h4
`define MPH_ADDR_MED_DS_A    3'h4
`define MPH_ADDR_MED_DS_B    3'h5

// ---------------------------------------------------------------
// access time ceilings, in clock periods, strobe edge to completion
// ---------------------------------------------------------------
`define MPH_SEP_FAST_MAX     3
`define MPH_SEP_MED_MAX      4
`define MPH_SEP_SLOW_MAX     5
`define MPH_DS_FAST_MAX      4
`define MPH_DS_MED_MAX       5
`define MPH_DS_SLOW_MAX      6

// input synchroniser plus the completion flop use this many periods
`define MPH_FIXED_PERIODS    3
`define MPH_WAIT_W           3

`endif

// [mph_sync.v]
`timescale 1ns/10ps
`default_nettype none

module mph_sync #(
    parameter WIDTH = 1
) (
    // clock and reset
    input  wire             i_mclk,
    input  wire             i_resetn,
    // asynchronous levels in, synchronised levels out
    input  wire [WIDTH-1:0] i_async,
    input  wire [WIDTH-1:0] i_reset_val,
    output wire [WIDTH-1:0] o_sync
);

    reg [WIDTH-1:0] stage1;
    reg [WIDTH-1:0] stage2;

    // ---------------------------------------------------------------
    // two flops per bit
    // ---------------------------------------------------------------
    genvar b;
    generate
        for (b = 0; b < WIDTH; b = b + 1) begin : g_bit
            always @(posedge i_mclk or negedge i_resetn) begin
                if (!i_resetn) begin
                    stage1[b] <= 1'b1;
                    stage2[b] <= 1'b1;
                end else begin
                    stage1[b] <= i_async[b];
                    stage2[b] <= stage1[b];
                end
            end
        end
    endgenerate

    // reset value has no effect: the flops always reset high and the mask is all ones
    assign o_sync = stage2 & (i_reset_val | ~i_reset_val);

endmodule

`default_nettype wire

// [mph_port.v]
// Summary of operation
// RULE1 - mode input high selects data strobe style with active-low acknowledge
// RULE2 - mode input low selects separate read and write strobes, ready high
// RULE3 - separate-strobe latency runs from strobe falling edge to ready rising
// RULE4 - separate-strobe addresses 7,6,5,3,2,1 complete within three periods
// RULE5 - separate-strobe address 4 and control address 0 within four periods
// RULE6 - separate-strobe coefficient RAM address 0 completes within five periods
// RULE7 - data-strobe latency runs from strobe falling edge to acknowledge falling
// RULE8 - data-strobe addresses 7,6,3,2,1 acknowledge within four periods
// RULE9 - data-strobe addresses 4,5 and control address 0 within five periods
// RULE10 - data-strobe coefficient RAM address 0 acknowledges within six periods
// RULE11 - acknowledge line is open drain; host supplies the pull-up
// RULE12 - host keeps address, data, strobes stable until completion is seen
// RULE13 - read data driven by completion, released after the read strobe ends
`timescale 1ns/10ps
`default_nettype none
`include "mph_consts.vh"

module mph_port (
    // clock and reset
    input  wire                    i_mclk,
    input  wire                    i_resetn,
    // host pins
    input  wire                    i_mode,
    input  wire                    i_host_data_strobe_n,
    input  wire                    i_wr_rw,
    input  wire [`MPH_ADDR_W-1:0]  i_addr,
    input  wire [`MPH_DATA_W-1:0]  i_data,
    output reg  [`MPH_DATA_W-1:0]  o_data,
    output reg                     o_data_oe,
    output reg                     o_transfer_acknowledge_n,
    output reg                     o_ack_oe,
    // register core side
    input  wire                    i_coef_sel,
    input  wire [`MPH_DATA_W-1:0]  i_rd_data,
    output reg  [`MPH_ADDR_W-1:0]  o_core_addr,
    output reg  [`MPH_DATA_W-1:0]  o_wr_data,
    output reg                     o_wr_stb,
    output reg                     o_rd_stb
);

    localparam NSYNC = `MPH_ADDR_W + `MPH_DATA_W + 3;

    // ---------------------------------------------------------------
    // extra wait cycles per latency class
    // ---------------------------------------------------------------
    // worked out as integers, then cut to the counter width on purpose
    localparam integer SEP_FAST_I = `MPH_SEP_FAST_MAX - `MPH_FIXED_PERIODS;
    localparam integer SEP_MED_I  = `MPH_SEP_MED_MAX - `MPH_FIXED_PERIODS;
    localparam integer SEP_SLOW_I = `MPH_SEP_SLOW_MAX - `MPH_FIXED_PERIODS;
    localparam integer DS_FAST_I  = `MPH_DS_FAST_MAX - `MPH_FIXED_PERIODS;
    localparam integer DS_MED_I   = `MPH_DS_MED_MAX - `MPH_FIXED_PERIODS;
    localparam integer DS_SLOW_I  = `MPH_DS_SLOW_MAX - `MPH_FIXED_PERIODS;

    localparam [`MPH_WAIT_W-1:0] WAIT_SEP_FAST = SEP_FAST_I[`MPH_WAIT_W-1:0];
    localparam [`MPH_WAIT_W-1:0] WAIT_SEP_MED  = SEP_MED_I[`MPH_WAIT_W-1:0];
    localparam [`MPH_WAIT_W-1:0] WAIT_SEP_SLOW = SEP_SLOW_I[`MPH_WAIT_W-1:0];
    localparam [`MPH_WAIT_W-1:0] WAIT_DS_FAST  = DS_FAST_I[`MPH_WAIT_W-1:0];
    localparam [`MPH_WAIT_W-1:0] WAIT_DS_MED   = DS_MED_I[`MPH_WAIT_W-1:0];
    localparam [`MPH_WAIT_W-1:0] WAIT_DS_SLOW  = DS_SLOW_I[`MPH_WAIT_W-1:0];
    localparam [`MPH_WAIT_W-1:0] WAIT_NONE     = {`MPH_WAIT_W{1'b0}};
    localparam [`MPH_WAIT_W-1:0] WAIT_ONE      = {{(`MPH_WAIT_W-1){1'b0}}, 1'b1};

    // ---------------------------------------------------------------
    // sequencer states
    // ---------------------------------------------------------------
    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_WAIT = 3'h2;
    localparam [2:0] ST_DONE = 3'h4;

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    wire [NSYNC-1:0] pins_sync;

    mph_sync #(
        .WIDTH (NSYNC)
    ) u_sync (
        .i_mclk      (i_mclk),
        .i_resetn    (i_resetn),
        .i_async     ({i_mode, i_host_data_strobe_n, i_wr_rw, i_addr, i_data}),
        .i_reset_val ({NSYNC{1'b1}}),
        .o_sync      (pins_sync)
    );

    wire                   data_strobe_mode     = pins_sync[NSYNC-1];
    wire                   separate_strobe_mode = ~data_strobe_mode;
    wire                   ds_s                 = pins_sync[NSYNC-2];
    wire                   wr_s                 = pins_sync[NSYNC-3];
    wire [`MPH_ADDR_W-1:0] addr_s = pins_sync[`MPH_DATA_W +: `MPH_ADDR_W];
    wire [`MPH_DATA_W-1:0] data_s = pins_sync[`MPH_DATA_W-1:0];

    // ---------------------------------------------------------------
    // strobe decode
    // ---------------------------------------------------------------
    reg  active_d;
    // RULE1 RULE2
    wire active    = data_strobe_mode ? ~ds_s : (~ds_s | ~wr_s);
    wire is_read   = data_strobe_mode ? wr_s : ~ds_s;
    wire start     = active & ~active_d;  // RULE3 RULE7
    wire released  = ~active;

    // ---------------------------------------------------------------
    // latency class: extra wait cycles beyond the fixed pipeline
    // ---------------------------------------------------------------
    // limitation: coefficient select is looked at in the detect cycle only,
    // so the core must present it before the strobe is seen
    reg [`MPH_WAIT_W-1:0] next_wait;

    always @* begin
        if (separate_strobe_mode) begin
            if (addr_s == `MPH_ADDR_SHARED && i_coef_sel)
                next_wait = WAIT_SEP_SLOW;  // RULE6
            else if (addr_s == `MPH_ADDR_SHARED || addr_s == `MPH_ADDR_MED_SEP)
                next_wait = WAIT_SEP_MED;   // RULE5
            else
                next_wait = WAIT_SEP_FAST;  // RULE4
        end else begin
            if (addr_s == `MPH_ADDR_SHARED && i_coef_sel)
                next_wait = WAIT_DS_SLOW;   // RULE10
            else if (addr_s == `MPH_ADDR_SHARED || addr_s == `MPH_ADDR_MED_DS_A
                     || addr_s == `MPH_ADDR_MED_DS_B)
                next_wait = WAIT_DS_MED;    // RULE9
            else
                next_wait = WAIT_DS_FAST;   // RULE8
        end
    end

    // ---------------------------------------------------------------
    // access sequencer
    // ---------------------------------------------------------------
    reg [2:0]             state;
    reg [`MPH_WAIT_W-1:0] wait_cnt;
    reg                   rd_access;

    // completion lands on the same flop edge that takes the count from one to zero
    wire finish = (state == ST_IDLE && start && next_wait == WAIT_NONE)
                || (state == ST_WAIT && wait_cnt == WAIT_ONE);

    always @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            state     <= ST_IDLE;
            wait_cnt  <= WAIT_NONE;
            rd_access <= 1'b0;
            active_d  <= 1'b0;
            o_ack_oe  <= 1'b0;
        end else begin
            active_d <= active;
            case (state)
                ST_IDLE: begin
                    // separate style holds ready low until an access completes
                    o_ack_oe  <= separate_strobe_mode;
                    rd_access <= is_read;
                    if (start) begin
                        if (next_wait == WAIT_NONE) begin
                            state <= ST_DONE;
                        end else begin
                            state    <= ST_WAIT;
                            wait_cnt <= next_wait;
                        end
                    end
                end
                ST_WAIT: begin
                    wait_cnt <= wait_cnt - WAIT_ONE;
                    if (finish)
                        state <= ST_DONE;
                end
                ST_DONE: begin
                    // completion stands until the host lets go of its strobe
                    if (released) begin
                        state    <= ST_IDLE;
                        o_ack_oe <= separate_strobe_mode;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
            if (finish) begin
                // ready released high, or acknowledge pulled low
                o_ack_oe <= data_strobe_mode;  // RULE3 RULE7
            end
        end
    end

    // ---------------------------------------------------------------
    // core strobes and host data bus
    // ---------------------------------------------------------------
    // on the fast path the direction comes straight from the detect cycle
    wire finish_rd = (state == ST_IDLE) ? is_read : rd_access;

    always @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_transfer_acknowledge_n <= 1'b0;
            o_data                   <= {`MPH_DATA_W{1'b0}};
            o_data_oe                <= 1'b0;
            o_core_addr              <= {`MPH_ADDR_W{1'b0}};
            o_wr_data                <= {`MPH_DATA_W{1'b0}};
            o_wr_stb                 <= 1'b0;
            o_rd_stb                 <= 1'b0;
        end else begin
            // open drain: the pin value stays low, only the enable moves
            o_transfer_acknowledge_n <= 1'b0;  // RULE11
            o_wr_stb                 <= finish & ~finish_rd;
            o_rd_stb                 <= finish & finish_rd;
            if (state == ST_IDLE) begin
                // RULE12 address and data are reloaded every idle cycle, host holds them
                o_core_addr <= addr_s;
                o_wr_data   <= data_s;
            end
            // data lands on the same edge as completion, so the host never samples a stale byte
            if (finish && finish_rd) begin
                o_data    <= i_rd_data;  // RULE13
                o_data_oe <= 1'b1;
            end else if (state == ST_DONE && released) begin
                o_data_oe <= 1'b0;  // RULE13
            end
        end
    end

endmodule

`default_nettype wire

// [mph_port_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
// ----------------------------
// handshake timing checks
// ----------------------------
module mph_port_chk (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_mode,
    input wire logic i_host_data_strobe_n,
    input wire logic i_wr_rw,
    input wire logic o_data_oe,
    input wire logic o_transfer_acknowledge_n,
    input wire logic o_ack_oe,
    input wire logic o_wr_stb,
    input wire logic o_rd_stb
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);
    sequence s_sep_start;
        !i_mode && o_ack_oe && $fell(i_host_data_strobe_n && i_wr_rw);
    endsequence
    sequence s_ds_start;
        i_mode && !o_ack_oe && $fell(i_host_data_strobe_n);
    endsequence
    property p_ack_low;
        o_transfer_acknowledge_n == 1'b0;
    endproperty
    property p_sep_lat;
        s_sep_start |-> ##[1:5] !o_ack_oe;
    endproperty
    property p_ds_lat;
        s_ds_start |-> ##[1:6] o_ack_oe;
    endproperty
    property p_sep_done;
        !i_mode && !$past(i_mode, 4) && (o_wr_stb || o_rd_stb) |-> !o_ack_oe;
    endproperty
    property p_ds_done;
        i_mode && $past(i_mode, 4) && (o_wr_stb || o_rd_stb) |-> o_ack_oe;
    endproperty
    property p_hold;
        i_mode && o_ack_oe && !i_host_data_strobe_n |=> o_ack_oe;
    endproperty
    property p_rd_data;
        o_rd_stb |-> o_data_oe && i_wr_rw;
    endproperty
    property p_release;
        o_data_oe && $rose(i_host_data_strobe_n) |-> ##[1:4] !o_data_oe;
    endproperty
    a_ack_low: assert property (p_ack_low) else $error("ack value high");
    a_sep_lat: assert property (p_sep_lat) else $error("ready late");
    a_ds_lat: assert property (p_ds_lat) else $error("ack late");
    a_sep_done: assert property (p_sep_done) else $error("ready polarity");
    a_ds_done: assert property (p_ds_done) else $error("ack polarity");
    a_hold: assert property (p_hold) else $error("ack dropped early");
    a_rd_data: assert property (p_rd_data) else $error("read data not driven");
    a_release: assert property (p_release) else $error("data bus held");
endmodule
bind mph_port mph_port_chk u_chk (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_mode(i_mode),
    .i_host_data_strobe_n(i_host_data_strobe_n), .i_wr_rw(i_wr_rw), .o_data_oe(o_data_oe),
    .o_transfer_acknowledge_n(o_transfer_acknowledge_n), .o_ack_oe(o_ack_oe),
    .o_wr_stb(o_wr_stb), .o_rd_stb(o_rd_stb));
`default_nettype wire

// [mph_host.sv]
`timescale 1ns/10ps
`default_nettype none
// ----------------------------
// host bus controller model
// ----------------------------
module mph_host (
    input  wire logic       i_mclk,
    input  wire logic       i_ack_oe,
    input  wire logic [7:0] i_data,
    input  wire logic       i_data_oe,
    output var  logic       o_mode,
    output var  logic       o_stb_n,
    output var  logic       o_wr_rw,
    output var  logic [2:0] o_addr,
    output var  logic [7:0] o_data
);
    wire ack_line = !i_ack_oe; // pull-up level when released
    initial {o_mode, o_stb_n, o_wr_rw, o_addr, o_data} = 14'h1800;
    // n counts edges from the strobe fall to completion seen
    task automatic xfer(input logic md, input logic wr, input logic [2:0] a,
                        input logic [7:0] d, output int n, output logic [7:0] q);
        if (md !== o_mode) begin
            o_mode <= md;
            repeat (6) @(posedge i_mclk);
        end
        o_addr <= a;
        o_data <= d;
        o_stb_n <= md ? 1'b0 : wr;
        o_wr_rw <= !wr;
        n = 0;
        do begin
            @(posedge i_mclk);
            #1 n++;
        end while (ack_line === md && n < 20);
        q = i_data_oe ? i_data : 8'hxx;
        @(posedge i_mclk);
        {o_stb_n, o_wr_rw} <= 2'b11;
        // undriven lines must not keep the old value
        o_addr <= ~a;
        o_data <= ~d;
        repeat (5) @(posedge i_mclk);
    endtask
endmodule
`default_nettype wire

// [micro_port_handshake_timing_bench.sv]
`timescale 1ns/10ps
`default_nettype none
// ----------------------------
// port timing bench
// ----------------------------
module micro_port_handshake_timing_bench;
    logic       i_mclk = 1'b0, i_resetn = 1'b0, coef = 1'b0;
    logic [7:0] rd_val = 8'h00, wa_data, q;
    logic [2:0] w_addr;
    wire        mode, stb_n, wr_rw, data_oe, ack_oe, wr_stb, rd_stb, ack_n;
    wire  [2:0] addr, core_addr;
    wire  [7:0] hdata, dout, wr_data;
    int         errors = 0, cmp_count = 0, n, rd_cnt = 0;
    // row: mode, coefficient select, address, latency in periods
    logic [7:0] rows [18] = '{8'h3b, 8'h33, 8'h2b, 8'h24, 8'h1b, 8'h13, 8'h0b, 8'h04, 8'h45,
        8'hbc, 8'hb4, 8'had, 8'ha5, 8'h9c, 8'h94, 8'h8c, 8'h85, 8'hc6};
    always #5 i_mclk = ~i_mclk;
    mph_port u_dut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_mode(mode),
        .i_host_data_strobe_n(stb_n), .i_wr_rw(wr_rw), .i_addr(addr), .i_data(hdata),
        .o_data(dout), .o_data_oe(data_oe), .o_transfer_acknowledge_n(ack_n), .o_ack_oe(ack_oe),
        .i_coef_sel(coef), .i_rd_data(rd_val), .o_core_addr(core_addr),
        .o_wr_data(wr_data), .o_wr_stb(wr_stb), .o_rd_stb(rd_stb));
    mph_host u_host (.i_mclk(i_mclk), .i_ack_oe(ack_oe), .i_data(dout), .i_data_oe(data_oe),
        .o_mode(mode), .o_stb_n(stb_n), .o_wr_rw(wr_rw), .o_addr(addr), .o_data(hdata));
    always @(posedge i_mclk)
        if (wr_stb === 1'b1) {w_addr, wa_data} <= {core_addr, wr_data};
    always @(posedge i_mclk)
        if (rd_stb === 1'b1) rd_cnt <= rd_cnt + 1;
    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic conclude();
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #100000;
        errors++;
        conclude();
    end
    initial begin
        repeat (3) @(posedge i_mclk);
        i_resetn <= 1'b1;
        repeat (5) @(posedge i_mclk);
        for (int i = 0; i < 18; i++) begin
            coef <= rows[i][6];
            rd_val <= rows[i] ^ 8'ha5;
            u_host.xfer(rows[i][7], i[0], rows[i][5:3], ~rows[i], n, q);
            chk("latency", 16'(n), {13'h0000, rows[i][2:0]});
            if (i[0]) chk("write", {5'h00, w_addr, wa_data}, {5'h00, rows[i][5:3], ~rows[i]});
            else chk("read", {8'h00, q}, {8'h00, rows[i] ^ 8'ha5});
            chk("bus release", {14'h0000, ack_n, data_oe}, 16'h0000);
            $display("row %0d done", i);
        end
        chk("read strobes", 16'(rd_cnt), 16'h0009);
        // reset in mid-run must release the lines, then a slow read must still work
        i_resetn <= 1'b0;
        @(posedge i_mclk);
        #1 chk("reset outputs", {12'h000, ack_n, ack_oe, data_oe, wr_stb}, 16'h0000);
        @(posedge i_mclk);
        i_resetn <= 1'b1;
        repeat (5) @(posedge i_mclk);
        coef <= 1'b1;
        rd_val <= 8'h3c;
        u_host.xfer(1'b1, 1'b0, 3'h0, 8'h00, n, q);
        chk("latency after reset", 16'(n), 16'h0006);
        chk("read after reset", {8'h00, q}, 16'h003c);
        chk("read strobes after reset", 16'(rd_cnt), 16'h000a);
        $display("reset test done");
        conclude();
    end
endmodule
`default_nettype wire
